//--- logic/lrc_bank.v
// control register bank and decision logic for linear regulator one
// Operation
// - undervoltage action: ignore, regulator off, device reset
// - every undervoltage fault raises an interrupt; here only when its event is enabled in irq_en
// - source field picks hardware control input(s)
// - hardware control voltage from on or sleep
// - hardware mode: low power, off, on mode
// - float versus discharge when off; switch mode bit
// - variant bit picks 50mA or 20mA low power
// - on slot: off, timeslot 1-5, hardware enables
// - on mode bit: normal or low power
// - on voltage code drives regulator, resets zero
// - sleep slot: transition or disable per timeslot
// - hardware enabled: codes 1-5 pick sleep entry
// - sleep mode bit: normal or low power, resets 1
// - sleep voltage code same mapping, resets zero
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "lrc_defs.vh"

module lrc_bank
(
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // sequencer timebase
    input wire seq_sleep,
    input wire slot_strobe,
    input wire [2:0] slot_num,
    // hardware control and enable inputs
    input wire hw_control_input_1,
    input wire hw_control_input_2,
    input wire hw_enable_1,
    input wire hw_enable_2,
    // analog fault report
    input wire uv_fault,
    // regulator drive
    output reg reg_enable,
    output reg reg_low_power,
    output reg reg_lp_20ma,
    output reg [4:0] reg_voltage_code,
    output reg reg_discharge,
    output reg reg_switch_mode,
    // system
    output reg device_reset_req,
    output reg irq
);

    // word index of a byte address, or all ones if out of range or not word aligned
    function [15:0] word_index;
        input [31:0] addr;
        begin
            if (addr[31:18] != 14'h0000 || addr[1:0] != 2'h0)
                word_index = 16'hffff;
            else
                word_index = addr[17:2];
        end
    endfunction

    // sleep transition or disable timeslot of a sleep slot code
    function [2:0] sleep_time;
        input [2:0] code;
        begin
            case (code)
                3'h0: sleep_time = 3'h5;
                3'h6: sleep_time = 3'h3;
                3'h7: sleep_time = 3'h1;
                default: sleep_time = `LRC_SLOT_TOP - code;
            endcase
        end
    endfunction

    // software registers
    reg [15:0] ctrl_reg; // fault action and hardware control
    reg [15:0] on_reg; // on slot, mode and voltage
    reg [15:0] sleep_reg; // sleep slot, mode and voltage
    reg [`LRC_EV_W-1:0] status; // sticky events
    reg [`LRC_EV_W-1:0] irq_en; // interrupt enables
    // bus data phase state
    reg wr_pend; // write data phase in progress
    reg [15:0] wr_idx; // index captured in address phase
    // sequencer state
    reg seq_on; // enabled by its power-up slot
    reg use_sleep; // sleep fields in force
    reg fault_off; // switched off by undervoltage
    // next values
    reg [15:0] next_ctrl;
    reg [15:0] next_on;
    reg [15:0] next_sleep;
    reg [`LRC_EV_W-1:0] next_status;
    reg [`LRC_EV_W-1:0] next_irq_en;
    reg [31:0] next_rdata;
    reg next_enable;
    reg next_lp;
    reg [4:0] next_vcode;

    // field views
    wire [1:0] undervoltage_action = ctrl_reg[`LRC_ACT_HI:`LRC_ACT_LO];
    wire [1:0] hw_control_source = ctrl_reg[`LRC_SRC_HI:`LRC_SRC_LO];
    wire hw_control_voltage_pick = ctrl_reg[`LRC_VPICK];
    wire [1:0] hw_control_op_mode =
        ctrl_reg[`LRC_HMODE_HI:`LRC_HMODE_LO];
    wire output_float_select = ctrl_reg[`LRC_FLOAT];
    wire switch_operation_select = ctrl_reg[`LRC_SWITCH];
    wire low_power_variant = ctrl_reg[`LRC_LPVAR];
    wire [2:0] power_up_slot = on_reg[`LRC_SLOT_HI:`LRC_SLOT_LO];
    wire on_op_mode = on_reg[`LRC_MODE];
    wire [4:0] on_voltage_code = on_reg[`LRC_VC_HI:`LRC_VC_LO];
    wire [2:0] sleep_slot = sleep_reg[`LRC_SLOT_HI:`LRC_SLOT_LO];
    wire sleep_op_mode = sleep_reg[`LRC_MODE];
    wire [4:0] sleep_voltage_code = sleep_reg[`LRC_VC_HI:`LRC_VC_LO];

    // address phase of a valid transfer
    wire addr_phase = hsel & htrans[1] & hready;
    // data phase write to a given index
    wire wr_ctrl = wr_pend & (wr_idx == `LRC_IDX_CTRL);
    wire wr_on = wr_pend & (wr_idx == `LRC_IDX_ON);
    wire wr_sleep = wr_pend & (wr_idx == `LRC_IDX_SLEEP);
    wire wr_en = wr_pend & (wr_idx == `LRC_IDX_IRQ_EN);
    wire wr_clr = wr_pend & (wr_idx == `LRC_IDX_IRQ_CLR);

    // hardware control asserted by the selected input(s)
    wire hwc_active = (hw_control_source[0] & hw_control_input_1) |
        (hw_control_source[1] & hw_control_input_2);
    // power-up handed to a hardware enable input
    wire hwe_assigned = (power_up_slot == `LRC_SLOT_HWE1) |
        (power_up_slot == `LRC_SLOT_HWE2);
    wire hwe_level = (power_up_slot == `LRC_SLOT_HWE1) ?
        hw_enable_1 : hw_enable_2;
    // sleep code that disables instead of transitioning
    wire sleep_disables = (sleep_slot != `LRC_SLOT_NONE) &
        (sleep_slot <= `LRC_SLOT_MAX);
    // timeslot strobes that matter this cycle
    wire on_hit = slot_strobe & ~seq_sleep & (slot_num == power_up_slot)
        & (power_up_slot != `LRC_SLOT_NONE) & ~hwe_assigned;
    wire sleep_hit = slot_strobe & seq_sleep &
        (slot_num == sleep_time(sleep_slot));

    // register writes; writes land in the data phase
    always @*
    begin
        next_ctrl = ctrl_reg;
        next_on = on_reg;
        next_sleep = sleep_reg;
        next_irq_en = irq_en;
        if (wr_ctrl)
            next_ctrl = hwdata[15:0] & `LRC_MASK_CTRL;
        if (wr_on)
            next_on = hwdata[15:0] & `LRC_MASK_SLOT;
        if (wr_sleep)
            next_sleep = hwdata[15:0] & `LRC_MASK_SLOT;
        if (wr_en)
            next_irq_en = hwdata[`LRC_EV_W-1:0];
    end

    // sticky events: a clear in the same cycle loses to a new event
    always @*
    begin
        next_status = status;
        if (wr_clr)
            next_status = status & ~hwdata[`LRC_EV_W-1:0];
        if (uv_fault)
            next_status[`LRC_EV_UV] = 1'b1;
        if (uv_fault && undervoltage_action == `LRC_ACT_OFF)
            next_status[`LRC_EV_OFF] = 1'b1;
        if (uv_fault && undervoltage_action == `LRC_ACT_RESET)
            next_status[`LRC_EV_RST] = 1'b1;
    end

    // read data from next values so a write then read sees the write
    always @*
    begin
        next_rdata = 32'h00000000;
        case (word_index(haddr))
            `LRC_IDX_CTRL: next_rdata[15:0] = next_ctrl;
            `LRC_IDX_ON: next_rdata[15:0] = next_on;
            `LRC_IDX_SLEEP: next_rdata[15:0] = next_sleep;
            `LRC_IDX_STATUS: next_rdata[`LRC_EV_W-1:0] = next_status;
            `LRC_IDX_IRQ_EN: next_rdata[`LRC_EV_W-1:0] = next_irq_en;
            `LRC_IDX_LIVE: next_rdata[9:0] = {fault_off, use_sleep,
                seq_on, reg_low_power, reg_enable, reg_voltage_code};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // regulator drive decision
    always @*
    begin
        // normal path: on or sleep fields by sequencer state
        next_vcode = use_sleep ? sleep_voltage_code : on_voltage_code;
        next_lp = use_sleep ? sleep_op_mode : on_op_mode;
        next_enable = hwe_assigned ? hwe_level : seq_on;
        if (hwe_assigned && !hwe_level)
            next_enable = 1'b0;
        if (hwc_active)
        begin
            // hardware control overrides voltage and mode
            next_vcode = hw_control_voltage_pick ?
                sleep_voltage_code : on_voltage_code;
            case (hw_control_op_mode)
                `LRC_HMODE_OFF: next_enable = 1'b0;
                `LRC_HMODE_ON: next_lp = on_op_mode;
                default: next_lp = 1'b1;
            endcase
        end
        if (fault_off)
            next_enable = 1'b0;
    end

    // bus slave: always ready, always okay
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= 1'b0;
            wr_idx <= 16'h0000;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= addr_phase & hwrite;
            if (addr_phase)
                wr_idx <= word_index(haddr);
            // read data stands through the data phase
            if (addr_phase && !hwrite)
                hrdata <= next_rdata;
        end
    end

    // register storage and interrupt
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_reg <= `LRC_RST_CTRL;
            on_reg <= `LRC_RST_ON;
            sleep_reg <= `LRC_RST_SLEEP;
            status <= {`LRC_EV_W{1'b0}};
            irq_en <= {`LRC_EV_W{1'b0}};
            irq <= 1'b0;
        end
        else
        begin
            ctrl_reg <= next_ctrl;
            on_reg <= next_on;
            sleep_reg <= next_sleep;
            status <= next_status;
            irq_en <= next_irq_en;
            irq <= |(next_status & next_irq_en);
        end
    end

    // power-up and sleep sequencing
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            seq_on <= 1'b0;
            use_sleep <= 1'b0;
        end
        else
        begin
            if (on_hit)
            begin
                // enabled with on fields in its power-up slot
                seq_on <= 1'b1;
                use_sleep <= 1'b0;
            end
            else if (!seq_sleep && hwe_assigned)
                use_sleep <= 1'b0;
            else if (sleep_hit)
            begin
                if (sleep_disables && !hwe_assigned)
                    seq_on <= 1'b0;
                else
                    use_sleep <= 1'b1;
            end
            // power-up slot cleared: nothing enables it
            if (power_up_slot == `LRC_SLOT_NONE)
                seq_on <= 1'b0;
        end
    end

    // undervoltage handling
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fault_off <= 1'b0;
            device_reset_req <= 1'b0;
        end
        else
        begin
            // one-cycle request to reset the whole device
            device_reset_req <= uv_fault &
                (undervoltage_action == `LRC_ACT_RESET);
            if (uv_fault && undervoltage_action == `LRC_ACT_OFF)
                fault_off <= 1'b1;
            else if (on_hit || wr_clr && hwdata[`LRC_EV_OFF])
                fault_off <= 1'b0;
        end
    end

    // registered regulator outputs
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            reg_enable <= 1'b0;
            reg_low_power <= 1'b0;
            reg_lp_20ma <= 1'b0;
            reg_voltage_code <= 5'h00;
            reg_discharge <= 1'b1;
            reg_switch_mode <= 1'b0;
        end
        else
        begin
            reg_enable <= next_enable;
            reg_low_power <= next_lp & next_enable;
            reg_lp_20ma <= next_lp & next_enable & low_power_variant;
            reg_voltage_code <= next_vcode;
            reg_discharge <= ~next_enable & ~output_float_select;
            reg_switch_mode <= switch_operation_select;
        end
    end

endmodule // lrc_bank

//--- logic/lrc_defs.vh
// constants for the linear regulator one control bank
`ifndef LRC_DEFS_VH
`define LRC_DEFS_VH

// register indices; byte address is four times the index
`define LRC_IDX_CTRL 16'h4068
`define LRC_IDX_ON 16'h4069
`define LRC_IDX_SLEEP 16'h406a
`define LRC_IDX_STATUS 16'h4070
`define LRC_IDX_IRQ_EN 16'h4071
`define LRC_IDX_IRQ_CLR 16'h4072
`define LRC_IDX_LIVE 16'h4073

// reset values
`define LRC_RST_CTRL 16'h0200
`define LRC_RST_ON 16'h0000
`define LRC_RST_SLEEP 16'h0100

// writable bit masks
`define LRC_MASK_CTRL 16'hdfc1
`define LRC_MASK_SLOT 16'he11f

// control register fields
`define LRC_ACT_HI 15
`define LRC_ACT_LO 14
`define LRC_SRC_HI 12
`define LRC_SRC_LO 11
`define LRC_VPICK 10
`define LRC_HMODE_HI 9
`define LRC_HMODE_LO 8
`define LRC_FLOAT 7
`define LRC_SWITCH 6
`define LRC_LPVAR 0

// on and sleep register fields
`define LRC_SLOT_HI 15
`define LRC_SLOT_LO 13
`define LRC_MODE 8
`define LRC_VC_HI 4
`define LRC_VC_LO 0

// error action codes
`define LRC_ACT_IGNORE 2'h0
`define LRC_ACT_OFF 2'h1
`define LRC_ACT_RESET 2'h2

// hardware control mode codes that turn the regulator off or select on mode
`define LRC_HMODE_OFF 2'h1
`define LRC_HMODE_ON 2'h3

// slot codes
`define LRC_SLOT_NONE 3'h0
`define LRC_SLOT_HWE1 3'h6
`define LRC_SLOT_HWE2 3'h7
`define LRC_SLOT_MAX 3'h5
`define LRC_SLOT_TOP 3'h6

// interrupt event bits
`define LRC_EV_UV 0
`define LRC_EV_OFF 1
`define LRC_EV_RST 2
`define LRC_EV_W 3

`endif

//--- verification/lrc_bank_assertions.sv
// port checker for the regulator control bank, bound to the design
`timescale 1ns/1ps
module lrc_bank_checker
(
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // bus side
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // fault event and regulator drive
    input wire uv_fault,
    input wire reg_enable,
    input wire reg_low_power,
    input wire reg_lp_20ma,
    input wire reg_discharge,
    input wire reg_switch_mode,
    input wire device_reset_req
);
    // a transfer is taken at this edge
    wire take = hsel && htrans[1] && hready;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_ready_high: assert property (hreadyout == 1'b1)
        else $error("slave stalled the bus");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(take && !hwrite))
        else $error("read data moved without a read");
    a_lp_variant: assert property (reg_lp_20ma |-> reg_low_power)
        else $error("20mA variant outside low power");
    a_lp_enabled: assert property (reg_low_power |-> reg_enable)
        else $error("low power while disabled");
    a_discharge_off: assert property (reg_discharge |-> !reg_enable)
        else $error("discharge while enabled");
    a_switch_write: assert property ($changed(reg_switch_mode) |->
        $past(take && hwrite, 3))
        else $error("switch mode moved without a write");
    a_reset_pulse: assert property (device_reset_req |=> !device_reset_req)
        else $error("device reset request too long");
    a_reset_cause: assert property (device_reset_req |->
        $past(uv_fault) || $past(uv_fault, 2))
        else $error("device reset without a fault");
    // main scenarios reached
    c_enable: cover property ($rose(reg_enable));
    c_dev_reset: cover property (device_reset_req);
    c_lp_20ma: cover property ($rose(reg_lp_20ma));
endmodule // lrc_bank_checker
bind lrc_bank lrc_bank_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .uv_fault(uv_fault), .reg_enable(reg_enable),
    .reg_low_power(reg_low_power), .reg_lp_20ma(reg_lp_20ma),
    .reg_discharge(reg_discharge), .reg_switch_mode(reg_switch_mode),
    .device_reset_req(device_reset_req));

//--- verification/lrc_bank_tb_top.sv
// self-checking bench for the regulator control bank
`timescale 1ns/1ps
`include "lrc_defs.vh"
module lrc_bank_tb_top;
    // driven inputs
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg seq_sleep = 1'b0;
    reg go = 1'b0;
    reg hc1 = 1'b0, hc2 = 1'b0, he1 = 1'b0, he2 = 1'b0, uv = 1'b0;
    // observed outputs
    wire [31:0] hrdata;
    wire hreadyout, hresp, slot_strobe, en, lp, lp20, dis, sw, drq, irq;
    wire [2:0] slot_num;
    wire [4:0] vc;
    // bookkeeping
    integer failures = 0, samples_checked = 0, cyc = 0, k;
    reg [31:0] d;
    reg [15:0] r;
    reg [4:0] von, vs;
    reg lpv;
    initial forever #25 hclk = ~hclk;
    lrc_bank u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .seq_sleep(seq_sleep),
        .slot_strobe(slot_strobe), .slot_num(slot_num),
        .hw_control_input_1(hc1), .hw_control_input_2(hc2),
        .hw_enable_1(he1), .hw_enable_2(he2), .uv_fault(uv),
        .reg_enable(en), .reg_low_power(lp), .reg_lp_20ma(lp20),
        .reg_voltage_code(vc), .reg_discharge(dis),
        .reg_switch_mode(sw), .device_reset_req(drq), .irq(irq));
    lrc_seq_model u_seq (.hclk(hclk), .hresetn(hresetn), .go(go),
        .slot_strobe(slot_strobe), .slot_num(slot_num), .busy());
    // verdict and end of run
    task summarize;
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // compare one value
    task chk(input [31:0] seen, input [31:0] exp, input string nm);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    // one single ahb-lite transfer, read data left in r
    task bus(input w, input [15:0] idx, input [31:0] wd);
    begin
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {14'h0, idx, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata[15:0];
    end
    endtask
    // let n edges pass; flopped outputs are read before that edge moves them
    task tick(input integer n);
    begin
        repeat (n) @(posedge hclk);
    end
    endtask
    // run the timeslots one to five
    task sweep;
    begin
        @(posedge hclk);
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        tick(14);
    end
    endtask
    // one undervoltage pulse; rq is the expected device reset request
    task fault(input rq);
    begin
        uv <= 1'b1;
        @(posedge hclk);
        uv <= 1'b0;
        @(posedge hclk);
        chk(drq, rq, "reset req");
        tick(2);
    end
    endtask
    // sleep codes that keep the regulator on with sleep fields
    function sleep_on(input [2:0] c);
        sleep_on = (c == 3'h0) || (c > 3'h5);
    endfunction
    // source code selects the asserted control input
    function hw_hit(input [2:0] c);
        hw_hit = c[2] ? c[1] : c[0];
    endfunction
    always @(posedge hclk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            failures = failures + 1;
            summarize;
        end
    end
    initial
    begin
        d = $urandom(32'h617aca3a);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values and an unmapped index
        bus(0, `LRC_IDX_CTRL, 0);
        chk(r, 16'h0200, "ctrl");
        bus(0, `LRC_IDX_ON, 0);
        chk(r, 16'h0000, "on");
        bus(0, `LRC_IDX_SLEEP, 0);
        chk(r, 16'h0100, "sleep");
        bus(0, 16'h4074, 0);
        chk(r, 16'h0000, "unmapped");
        // random readback of on and sleep settings
        for (k = 0; k < 4; k = k + 1)
        begin
            d = $urandom;
            bus(1, `LRC_IDX_ON + k[0], d);
            bus(0, `LRC_IDX_ON + k[0], 0);
            chk(r, d[15:0] & `LRC_MASK_SLOT, "readback");
        end
        von = $urandom;
        vs = $urandom;
        lpv = $urandom;
        bus(1, `LRC_IDX_CTRL, {16'h0, 15'h0100, lpv});
        // every sleep slot code after power-up in slot one
        for (k = 0; k < 8; k = k + 1)
        begin
            bus(1, `LRC_IDX_ON, {16'h0, 3'h1, 8'h0, von});
            bus(1, `LRC_IDX_SLEEP, {16'h0, k[2:0], 8'h08, vs});
            seq_sleep <= 1'b0;
            sweep;
            chk(en, 1, "on en");
            chk(vc, von, "on volt");
            chk(lp, 0, "on lp");
            seq_sleep <= 1'b1;
            sweep;
            chk(en, sleep_on(k), "slp en");
            if (sleep_on(k))
            begin
                chk(vc, vs, "slp volt");
                chk(lp, 1, "slp lp");
                chk(lp20, lpv, "slp 20ma");
            end
            else
                chk(dis, 1, "discharge");
        end
        // hardware enables one and two, sleep entry under enable two
        seq_sleep <= 1'b0;
        bus(1, `LRC_IDX_SLEEP, {16'h0, 3'h3, 8'h08, vs});
        for (k = 0; k < 2; k = k + 1)
        begin
            bus(1, `LRC_IDX_ON, {16'h0, 2'h3, k[0], 8'h0, von});
            he1 <= k[0];
            he2 <= !k[0];
            tick(3);
            chk(en, 0, "hwe other");
            he1 <= !k[0];
            he2 <= k[0];
            tick(3);
            chk(en, 1, "hwe own");
        end
        seq_sleep <= 1'b1;
        sweep;
        chk(en, 1, "hwe slp en");
        chk(vc, vs, "hwe slp volt");
        seq_sleep <= 1'b0;
        he2 <= 1'b0;
        tick(3);
        chk(en, 0, "hwe off");
        chk(dis, 1, "hwe dis");
        bus(1, `LRC_IDX_CTRL, 32'h02c0);
        tick(2);
        chk(dis, 0, "float");
        chk(sw, 1, "switch");
        // hardware control sources with mode off
        bus(1, `LRC_IDX_ON, {16'h0, 3'h1, 8'h0, von});
        sweep;
        for (k = 0; k < 8; k = k + 1)
        begin
            bus(1, `LRC_IDX_CTRL, {16'h0, 3'h0, k[1:0], 3'h1, 8'h0});
            hc1 <= !k[2];
            hc2 <= k[2];
            tick(3);
            chk(en, !hw_hit(k), "hwc src");
            hc1 <= 1'b0;
            hc2 <= 1'b0;
        end
        bus(1, `LRC_IDX_CTRL, 32'h0f00);
        hc1 <= 1'b1;
        tick(3);
        chk(vc, vs, "hwc vpick");
        chk(lp, 0, "hwc on mode");
        bus(1, `LRC_IDX_CTRL, 32'h0801);
        tick(3);
        chk(vc, von, "hwc von");
        chk(lp20, 1, "hwc lp");
        hc1 <= 1'b0;
        // undervoltage actions, interrupt raised, cleared and masked
        bus(1, `LRC_IDX_IRQ_EN, 1);
        bus(1, `LRC_IDX_CTRL, 32'h0200);
        fault(1'b0);
        chk(irq, 1, "irq");
        chk(en, 1, "ignore");
        bus(1, `LRC_IDX_IRQ_CLR, 1);
        tick(2);
        chk(irq, 0, "irq clr");
        bus(1, `LRC_IDX_CTRL, 32'h4200);
        fault(1'b0);
        chk(en, 0, "uv off");
        chk(irq, 1, "irq off");
        bus(1, `LRC_IDX_IRQ_CLR, 7);
        bus(1, `LRC_IDX_IRQ_EN, 0);
        bus(1, `LRC_IDX_CTRL, 32'h8200);
        fault(1'b1);
        chk(irq, 0, "irq mask");
        bus(0, `LRC_IDX_STATUS, 0);
        chk(r[2:0], 3'h5, "status");
        // live view: slot-enabled, enabled, on voltage, fault-off released
        bus(0, `LRC_IDX_LIVE, 0);
        chk(r, 16'h00a0 | von, "live");
        summarize;
    end
endmodule // lrc_bank_tb_top

//--- verification/lrc_seq_model.sv
// timebase model sweeping the startup timeslots one to five
`timescale 1ns/1ps
module lrc_seq_model
(
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // sweep request and slot strobes
    input wire go,
    output reg slot_strobe,
    output reg [2:0] slot_num,
    output wire busy
);
    // sweep step, zero while idle
    reg [3:0] step;
    assign busy = (step != 4'h0);
    // strobe every second step; slot number drifts between strobes
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            step <= 4'h0;
            slot_strobe <= 1'b0;
            slot_num <= 3'h0;
        end
        else
        begin
            step <= (go && !busy) ? 4'h1 :
                (busy && step != 4'hb) ? step + 4'h1 : 4'h0;
            slot_strobe <= busy && step[0] && step < 4'hb;
            slot_num <= step[3:1] + 3'h1;
        end
    end
endmodule // lrc_seq_model
